// ### hw/sdf_pkg.sv
// Purpose: Shared constants for the four-channel sinc decimation filter host
// Assumes: Modulator clock and bitstreams arrive asynchronously on pins
// Notes:   Counts of reference-clock cycles are derived from printed times
`default_nettype none

package sdf_pkg;
  localparam int unsigned NUM_CH        = 4;
  localparam int unsigned OSR_MIN       = 16;
  localparam int unsigned OSR_MAX       = 256;
  localparam int unsigned OSR_W         = 9;
  localparam int unsigned ACC_W         = 25;   // 3*log2(256)+1
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned REF_CLK_HZ    = 40000000;
  localparam int unsigned POR_WAIT_US   = 600;
  localparam int unsigned POR_WAIT_CYC  = POR_WAIT_US * (REF_CLK_HZ / 1000000);
  localparam int unsigned SETTLE3_WORDS = 3;
  localparam int unsigned SETTLE2_WORDS = 2;
  localparam logic [8:0]  OSR_RESET     = 9'h100;

  typedef enum logic [1:0] {
    SDF_ST_POR    = 2'b00,
    SDF_ST_SETTLE = 2'b01,
    SDF_ST_RUN    = 2'b10
  } sdf_state_t;
endpackage : sdf_pkg

`default_nettype wire

// ### hw/sdf_sync.sv
// Purpose: Two-flop synchroniser plus rising-edge detect of the second stage against a third
// Assumes: Input is asynchronous to ref_clk_i
// Notes:   First flop feeds only the second flop
`default_nettype none

module sdf_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] meta_q, meta_d;
  logic [W-1:0] stab_q, stab_d;
  logic [W-1:0] prev_q, prev_d;

  // Next-value logic
  always_comb begin
    meta_d = async_i;
    stab_d = meta_q;
    prev_d = stab_q;
  end

  // Registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      stab_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      stab_q <= stab_d;
      prev_q <= prev_d;
    end
  end

  assign sync_o = stab_q;
  assign rise_o = stab_q & ~prev_q;
endmodule : sdf_sync

`default_nettype wire

// ### hw/sdf_chan.sv
// Purpose: One channel of sinc3 and fast-settling sinc2 decimation
// Assumes: bit_en_i pulses once per modulator clock with the sampled bit
// Notes:   Combs run once per output word on the decimated integrator value
`default_nettype none

module sdf_chan
  import sdf_pkg::*;
#(
  parameter int unsigned AW = ACC_W
) (
  input  wire logic          ref_clk_i,
  input  wire logic          nrst_i,
  input  wire logic          bit_en_i,
  input  wire logic          bit_i,
  input  wire logic          dec_i,
  output logic      [AW-1:0] sinc3_o,
  output logic      [AW-1:0] sinc2_o,
  output logic      [AW-1:0] fast_o
);
  logic [AW-1:0] i1_q, i2_q, i3_q, i1_d, i2_d, i3_d;
  logic [AW-1:0] c3a_q, c3b_q, c3c_q, c3a_d, c3b_d, c3c_d;
  logic [AW-1:0] c2a_q, c2b_q, c2a_d, c2b_d;
  logic [AW-1:0] s2h1_q, s2h2_q, s2h1_d, s2h2_d;
  logic [AW-1:0] o3_q, o2_q, of_q, o3_d, o2_d, of_d;
  logic [AW-1:0] t1, t2, t3, u1, u2;

  // Integrators wrap freely; combs undo the overflow
  always_comb begin
    i1_d = i1_q;
    i2_d = i2_q;
    i3_d = i3_q;
    if (bit_en_i) begin
      i1_d = i1_q + {{(AW-1){1'b0}}, bit_i};
      i2_d = i2_q + i1_q;
      i3_d = i3_q + i2_q;
    end
  end

  // Combs, one step per data clock
  always_comb begin
    t1 = i3_q - c3a_q;
    t2 = t1 - c3b_q;
    t3 = t2 - c3c_q;
    u1 = i2_q - c2a_q;
    u2 = u1 - c2b_q;
    c3a_d = c3a_q; c3b_d = c3b_q; c3c_d = c3c_q;
    c2a_d = c2a_q; c2b_d = c2b_q;
    s2h1_d = s2h1_q; s2h2_d = s2h2_q;
    o3_d = o3_q; o2_d = o2_q; of_d = of_q;
    if (dec_i) begin
      c3a_d = i3_q; c3b_d = t1; c3c_d = t2;
      c2a_d = i2_q; c2b_d = u1;
      o3_d = t3;
      o2_d = u2;
      s2h1_d = u2;
      s2h2_d = s2h1_q;
      of_d = u2 + s2h2_q;
    end
  end

  // Registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      i1_q <= '0; i2_q <= '0; i3_q <= '0;
      c3a_q <= '0; c3b_q <= '0; c3c_q <= '0;
      c2a_q <= '0; c2b_q <= '0;
      s2h1_q <= '0; s2h2_q <= '0;
      o3_q <= '0; o2_q <= '0; of_q <= '0;
    end else begin
      i1_q <= i1_d; i2_q <= i2_d; i3_q <= i3_d;
      c3a_q <= c3a_d; c3b_q <= c3b_d; c3c_q <= c3c_d;
      c2a_q <= c2a_d; c2b_q <= c2b_d;
      s2h1_q <= s2h1_d; s2h2_q <= s2h2_d;
      o3_q <= o3_d; o2_q <= o2_d; of_q <= of_d;
    end
  end

  assign sinc3_o = o3_q;
  assign sinc2_o = o2_q;
  assign fast_o  = of_q;
endmodule : sdf_chan

`default_nettype wire

// ### hw/sdf_host.sv
// Purpose: Host-side four-channel sinc decimation filter for a delta-sigma modulator
// Assumes: Modulator clock and bitstreams are pins, sampled by ref_clk_i at 40 MHz
// Notes:   Modulator clock must stay below ref_clk_i/4 for reliable edge detection
`default_nettype none

module sdf_host
  import sdf_pkg::*;
#(
  parameter int unsigned POR_CYC = POR_WAIT_CYC
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      modulator_clock_out_i,
  input  wire logic [NUM_CH-1:0]         bitstream_out_i,
  input  wire logic [OSR_W-1:0]          osr_i,
  input  wire logic                      use_internal_osc_i,
  output logic                           clock_source_select_o,
  output logic                           external_clock_in_o,
  output logic                           ready_o,
  output logic                           word_valid_o,
  output logic                           word_settled_o,
  output logic [NUM_CH*WORD_W-1:0]       sinc3_word_o,
  output logic [NUM_CH*WORD_W-1:0]       sinc2_word_o,
  output logic [NUM_CH*WORD_W-1:0]       fast_word_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic              mclk_sync;
  logic              mclk_rise;
  logic [NUM_CH-1:0] bits_sync;
  logic [NUM_CH-1:0] bits_unused;
  logic              dec_pulse;
  sdf_state_t        state_q, state_d;

  // Clock and data pass the same two-flop delay, so each bit stays aligned
  sdf_sync #(.W(NUM_CH + 1)) u_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .async_i   ({modulator_clock_out_i, bitstream_out_i}),
    .sync_o    ({mclk_sync, bits_sync}),
    .rise_o    ({mclk_rise, bits_unused})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture

  logic [OSR_W-1:0] osr_q, osr_d;
  logic             sel_q, sel_d;

  // Ratio latched during the power-on wait and at word boundaries, so a change never splits a word
  always_comb begin
    osr_d = osr_q;
    sel_d = sel_q;
    if (dec_pulse || state_q == SDF_ST_POR) begin
      if (osr_i < OSR_W'(OSR_MIN))
        osr_d = OSR_W'(OSR_MIN);
      else if (osr_i > OSR_W'(OSR_MAX))
        osr_d = OSR_W'(OSR_MAX);
      else
        osr_d = osr_i;
    end
    if (state_q == SDF_ST_POR)
      sel_d = use_internal_osc_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data clock divider

  logic [OSR_W-1:0] div_q, div_d;

  // Counts modulator edges; strobe on the last of each OSR group
  always_comb begin
    div_d     = div_q;
    dec_pulse = 1'b0;
    if (mclk_rise && state_q != SDF_ST_POR) begin
      if (div_q == osr_q - OSR_W'(1)) begin
        div_d     = '0;
        dec_pulse = 1'b1;
      end else begin
        div_d = div_q + OSR_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-on wait and settling

  logic [19:0] por_q, por_d;
  logic [1:0]  settle_q, settle_d;

  always_comb begin
    state_d  = state_q;
    por_d    = por_q;
    settle_d = settle_q;
    case (state_q)
      SDF_ST_POR: begin
        if (por_q >= 20'(POR_CYC - 1))
          state_d = SDF_ST_SETTLE;
        else
          por_d = por_q + 20'h00001;
      end
      SDF_ST_SETTLE: begin
        if (dec_pulse) begin
          if (settle_q == 2'(SETTLE3_WORDS - 1))
            state_d = SDF_ST_RUN;
          else
            settle_d = settle_q + 2'h1;
        end
      end
      SDF_ST_RUN: begin
        state_d = SDF_ST_RUN;
      end
      default: begin
        state_d = SDF_ST_POR;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q  <= SDF_ST_POR;
      por_q    <= '0;
      settle_q <= '0;
      div_q    <= '0;
      osr_q    <= OSR_RESET;
      sel_q    <= 1'b1;
    end else begin
      state_q  <= state_d;
      por_q    <= por_d;
      settle_q <= settle_d;
      div_q    <= div_d;
      osr_q    <= osr_d;
      sel_q    <= sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  logic [NUM_CH*ACC_W-1:0] s3_raw, s2_raw, sf_raw;
  logic                    bit_en;

  assign bit_en = mclk_rise && state_q != SDF_ST_POR;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      sdf_chan #(.AW(ACC_W)) u_chan (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .bit_en_i  (bit_en),
        .bit_i     (bits_sync[g]),
        .dec_i     (dec_pulse),
        .sinc3_o   (s3_raw[g*ACC_W +: ACC_W]),
        .sinc2_o   (s2_raw[g*ACC_W +: ACC_W]),
        .fast_o    (sf_raw[g*ACC_W +: ACC_W])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Output word scaling

  logic [NUM_CH*WORD_W-1:0] w3_q, w2_q, wf_q, w3_d, w2_d, wf_d;
  logic                     vld_q, vld_d;
  logic                     pend_q, pend_d;
  logic [4:0]               sh3, sh2;
  logic [OSR_W-1:0]         osr_m1;

  // Shifts from ceil(log2(OSR)), so full scale never overflows a word
  always_comb begin
    osr_m1 = osr_q - OSR_W'(1);
    sh3    = 5'h03;
    sh2    = 5'h02;
    for (int k = 0; k < OSR_W; k++) begin
      if (osr_m1[k]) begin
        sh3 = 5'(3 * (k + 1));
        sh2 = 5'(2 * (k + 1));
      end
    end
  end

  // Channel outputs update the cycle after dec_pulse; capture then
  always_comb begin
    w3_d   = w3_q;
    w2_d   = w2_q;
    wf_d   = wf_q;
    vld_d  = 1'b0;
    pend_d = dec_pulse;
    if (pend_q) begin
      vld_d = 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
        w3_d[c*WORD_W +: WORD_W] = WORD_W'({s3_raw[c*ACC_W +: ACC_W], 16'h0000} >> (sh3 + 5'h1));
        w2_d[c*WORD_W +: WORD_W] = WORD_W'({s2_raw[c*ACC_W +: ACC_W], 16'h0000} >> (sh2 + 5'h1));
        wf_d[c*WORD_W +: WORD_W] = WORD_W'({sf_raw[c*ACC_W +: ACC_W], 16'h0000} >> (sh2 + 5'h2));
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w3_q   <= '0;
      w2_q   <= '0;
      wf_q   <= '0;
      vld_q  <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      w3_q   <= w3_d;
      w2_q   <= w2_d;
      wf_q   <= wf_d;
      vld_q  <= vld_d;
      pend_q <= pend_d;
    end
  end

  assign sinc3_word_o          = w3_q;
  assign sinc2_word_o          = w2_q;
  assign fast_word_o           = wf_q;
  assign word_valid_o          = vld_q;
  assign word_settled_o        = state_q == SDF_ST_RUN;
  assign ready_o               = state_q != SDF_ST_POR;
  assign clock_source_select_o = sel_q;
  assign external_clock_in_o   = 1'b0;
endmodule : sdf_host

`default_nettype wire

// ### sim/sdf_host_asserts.sv
// Purpose: Port checker for the sinc decimation host
// Assumes: Modulator clock period and osr_i stay fixed between resets
// Notes:   Bound onto every sdf_host instance at the foot of this file
`default_nettype none

module sdf_host_asserts
  import sdf_pkg::*;
#(
  parameter int unsigned POR_CYC = POR_WAIT_CYC
) (
  input wire logic                     ref_clk_i,
  input wire logic                     nrst_i,
  input wire logic                     modulator_clock_out_i,
  input wire logic [NUM_CH-1:0]        bitstream_out_i,
  input wire logic [OSR_W-1:0]         osr_i,
  input wire logic                     use_internal_osc_i,
  input wire logic                     clock_source_select_o,
  input wire logic                     external_clock_in_o,
  input wire logic                     ready_o,
  input wire logic                     word_valid_o,
  input wire logic                     word_settled_o,
  input wire logic [NUM_CH*WORD_W-1:0] sinc3_word_o,
  input wire logic [NUM_CH*WORD_W-1:0] sinc2_word_o,
  input wire logic [NUM_CH*WORD_W-1:0] fast_word_o
);
  logic [15:0] por_q;
  logic [2:0]  msync_q;
  logic [9:0]  ecnt_q;
  logic [1:0]  vcnt_q;
  logic [9:0]  osr_eff;
  logic        mod_edge;

  ////////////////////////////////////////////////////////////////////////
  // Clamped ratio, own edge finder; same sync depth keeps counts aligned
  assign osr_eff  = (osr_i < 9'h010) ? 10'h010 : (osr_i > 9'h100) ? 10'h100 : {1'b0, osr_i};
  assign mod_edge = msync_q[1] & ~msync_q[2];

  // Wait counter, edges per word, words since reset (saturating)
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      por_q   <= 16'h0000;
      msync_q <= 3'h0;
      ecnt_q  <= 10'h000;
      vcnt_q  <= 2'h0;
    end else begin
      if (por_q != 16'hFFFF) por_q <= por_q + 16'h0001;
      msync_q <= {msync_q[1:0], modulator_clock_out_i};
      ecnt_q  <= word_valid_o ? {9'h000, mod_edge} : ecnt_q + {9'h000, mod_edge};
      if (word_valid_o && vcnt_q != 2'h3) vcnt_q <= vcnt_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // A strobe is one cycle, then a quiet gap far shorter than any word
  sequence s_quiet_gap;
    ##1 !word_valid_o [*8];
  endsequence

  chk_strobe_single: assert property (word_valid_o |-> s_quiet_gap)
    else $error("word strobe too long or too close");
  chk_early_word: assert property (!ready_o |-> !word_valid_o)
    else $error("word before power-on wait ended");
  chk_por_wait: assert property (por_q < POR_CYC - 2 |-> !ready_o)
    else $error("ready before power-on wait");
  chk_por_done: assert property (por_q > POR_CYC + 4 |-> ready_o)
    else $error("ready late after power-on wait");
  chk_ready_hold: assert property (ready_o |=> ready_o)
    else $error("ready dropped");
  chk_ext_steady: assert property (clock_source_select_o |-> $stable(external_clock_in_o))
    else $error("external clock moved with internal source");
  chk_word_rate: assert property (word_valid_o && vcnt_q >= 2'h2 |-> ecnt_q == osr_eff)
    else $error("word rate differs from modulator clock over ratio");
  chk_words_hold: assert property (!word_valid_o |-> $stable(sinc3_word_o) && $stable(sinc2_word_o)
    && $stable(fast_word_o))
    else $error("words changed without strobe");
  chk_settle_early: assert property (word_settled_o |-> vcnt_q >= 2'h2)
    else $error("settled too early");
  chk_settle_due: assert property (vcnt_q == 2'h3 |-> word_settled_o)
    else $error("settled missing after three words");
endmodule // sdf_host_asserts

bind sdf_host sdf_host_asserts #(.POR_CYC(POR_CYC)) u_sdf_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .modulator_clock_out_i(modulator_clock_out_i),
  .bitstream_out_i(bitstream_out_i), .osr_i(osr_i), .use_internal_osc_i(use_internal_osc_i),
  .clock_source_select_o(clock_source_select_o), .external_clock_in_o(external_clock_in_o),
  .ready_o(ready_o), .word_valid_o(word_valid_o), .word_settled_o(word_settled_o),
  .sinc3_word_o(sinc3_word_o), .sinc2_word_o(sinc2_word_o), .fast_word_o(fast_word_o)
);

`default_nettype wire

// ### sim/sdf_dev_model.sv
// Purpose: Behavioural four-channel modulator for the host bench
// Assumes: Density per channel given in tenths of ones
// Notes:   Oscillator slowed so the host sees 200 ns modulator periods
`default_nettype none

module sdf_dev_model #(
  parameter int OSC_HALF_NS = 50
) (
  input  wire logic        clock_source_select_i,
  input  wire logic        external_clock_in_i,
  input  wire logic [15:0] density_i,
  output var  logic        modulator_clock_out_o,
  output var  logic [3:0]  bitstream_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       osc = 1'b0;
  logic       sys_clk;
  logic [4:0] acc [4];

  // Free-running internal oscillator, or the host pin when deselected
  always #(OSC_HALF_NS) osc = ~osc;
  assign sys_clk = clock_source_select_i ? osc : external_clock_in_i;

  // One shared clock pin, system clock halved
  initial modulator_clock_out_o = 1'b0;
  always @(posedge sys_clk) modulator_clock_out_o <= ~modulator_clock_out_o;

  // Density accumulator per channel, bits move on the falling edge
  initial begin
    bitstream_out_o = 4'h0;
    for (int c = 0; c < 4; c++) acc[c] = 5'h00;
  end
  always @(negedge modulator_clock_out_o) begin
    for (int c = 0; c < 4; c++) begin
      acc[c] = acc[c] + {1'b0, density_i[4*c+:4]};
      bitstream_out_o[c] <= (acc[c] >= 5'h0A);
      if (acc[c] >= 5'h0A) acc[c] = acc[c] - 5'h0A;
    end
  end
endmodule // sdf_dev_model

`default_nettype wire

// ### sim/testbench.sv
// Purpose: Self-checking bench for the sinc decimation host
// Assumes: Channel densities 80, 50, 20 and 50 percent ones
// Notes:   Only relative word checks, since the word scaling is approximate
`default_nettype none

module testbench;
  import sdf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned POR_SIM = 50;
  logic        ref_clk_i;
  logic        nrst_i;
  logic [8:0]  osr;
  logic        use_int;
  logic        sel;
  logic        ext_clk;
  logic        mclk;
  logic [3:0]  bits;
  logic        ready;
  logic        valid;
  logic        settled;
  logic [63:0] s3w;
  logic [63:0] s2w;
  logic [63:0] fw;
  logic [31:0] seed;
  logic [2:0]  exp_q [$];
  int          num_errors = 0;
  int          total_checks = 0;
  wire  [2:0]  rel = {s3w[15:0] > s3w[31:16], s2w[31:16] > s2w[47:32], fw[15:0] > fw[47:32]};

  sdf_host #(.POR_CYC(POR_SIM)) i_dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .modulator_clock_out_i(mclk), .bitstream_out_i(bits),
    .osr_i(osr), .use_internal_osc_i(use_int), .clock_source_select_o(sel),
    .external_clock_in_o(ext_clk), .ready_o(ready), .word_valid_o(valid), .word_settled_o(settled),
    .sinc3_word_o(s3w), .sinc2_word_o(s2w), .fast_word_o(fw));

  sdf_dev_model i_dev (.clock_source_select_i(sel), .external_clock_in_i(ext_clk),
    .density_i(16'h5258), .modulator_clock_out_o(mclk), .bitstream_out_o(bits));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Reset, wait out power-on, then note three settled word relations
  task automatic run_test(input logic [8:0] o);
    int n;
    @(negedge ref_clk_i);
    nrst_i = 1'b0;
    osr = o;
    repeat (2) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < POR_SIM + 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(ready, 1);
    check({sel, ext_clk}, 2'b10);
    repeat (3) exp_q.push_back(3'b111);
    n = 0;
    while (exp_q.size() != 0 && n < 30000) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(exp_q.size(), 0);
    exp_q.delete();
    $display("test with ratio %h done", o);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reference clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // Ratios below, inside and above the legal span
  initial begin
    nrst_i = 1'b0;
    osr = 9'h100;
    use_int = 1'b1;
    seed = 32'h0000004D;
    run_test(9'h005);
    seed = xs(seed);
    run_test(9'(16 + seed % 241));
    run_test(9'h1FF);
    complete_run();
  end

  // Higher density must give the larger word on every path
  always @(negedge ref_clk_i) begin
    if (valid === 1'b1 && settled === 1'b1 && exp_q.size() > 0) begin
      check(rel, exp_q.pop_front());
    end
  end

  // Hang guard, well above three full-ratio runs
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
endmodule // testbench

`default_nettype wire
